// ==== design/rdd_pkg.sv ====
package rdd_pkg;
	// ****************************************************************
	// register map (printed offsets are word indexes)
	// ****************************************************************
	localparam int AXI_AW = 24;
	localparam logic [19:0] IDX_BASE_LOW = 20'h48230;
	localparam logic [19:0] IDX_BASE_HIGH = 20'h48232;
	localparam logic [19:0] IDX_SOFT_TRIG = 20'h48234;
	localparam logic [19:0] IDX_GLOBAL_EN = 20'h48235;
	localparam logic [AXI_AW-1:0] ADDR_BASE_LOW = {2'h0, IDX_BASE_LOW, 2'h0};
	localparam logic [AXI_AW-1:0] ADDR_BASE_HIGH = {2'h0, IDX_BASE_HIGH, 2'h0};
	localparam logic [AXI_AW-1:0] ADDR_SOFT_TRIG = {2'h0, IDX_SOFT_TRIG, 2'h0};
	localparam logic [AXI_AW-1:0] ADDR_GLOBAL_EN = {2'h0, IDX_GLOBAL_EN, 2'h0};
	localparam logic [15:0] RST_BASE_LOW = 16'h03A0;
	localparam logic [11:0] RST_BASE_HIGH = 12'h0C0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ****************************************************************
	// control record layout
	// ****************************************************************
	localparam int NUM_HW_SRC = 27;
	localparam logic [27:0] REC_BYTES = 28'h00C;
	localparam int W1_CHAIN = 31;
	localparam int W2_IRQ_EN = 31;
	localparam int W2_HALF = 30;
	localparam logic [1:0] UPD_FIXED = 2'h0;
	localparam logic [1:0] UPD_DEC = 2'h1;
	localparam logic [1:0] UPD_INC_RESTORE = 2'h2;
	localparam logic [1:0] MODE_SINGLE = 2'h0;
	localparam logic [1:0] MODE_SUCC = 2'h1;
	localparam logic [1:0] MODE_BLOCK = 2'h2;
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_FETCH,
		ST_READ,
		ST_WRITE,
		ST_STORE,
		ST_DONE
	} rdd_state_t;

	typedef struct packed {
		logic req;
		logic we;
		logic [1:0] size;
		logic [27:0] addr;
		logic [31:0] wdata;
	} rdd_mem_req_t;

	typedef struct packed {
		logic valid;
		logic irq;
		logic hw;
		logic [6:0] chan;
	} rdd_done_t;
endpackage : rdd_pkg

// ==== design/rdd_engine.sv ====
// Contract
// - up to 128 channels; 27 startable by peripheral interrupt factors
// - three-word records placed contiguously from the base, channel 0 first
// - record address is base plus twelve times channel number
// - base held as 16-bit low and 12-bit high registers
// - base takes fixed default on reset
// - base writes ignored while transfer active
// - word one: chain enable, next channel, count, block size or count low
// - chain enable invokes next channel after completion; else operation ends
// - block uses 16-bit count and 8-bit size; else one 24-bit count
// - counts decrement per transfer; zero wraps to all ones
// - completion interrupt when enabled and count reaches zero
// - word two bit 30 picks half-word or byte unit
// - source code: fixed, increment, decrement by unit size
// - block mode code 10 restores source at block end
// - word three mode field: single, successive, block; never 11
// - single mode moves one unit per trigger
// - successive mode repeats units until count reaches zero
// - block mode moves one block per trigger
// - destination code and address behave like the source ones
// - global enable gates acceptance of all invocation requests
// - soft channel plus start bit launches; bit cleared on completion
// - invoking factor flag stays set until its transfer completes
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module rdd_engine import rdd_pkg::*; (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NUM_HW_SRC-1:0] hw_req,
	output rdd_mem_req_t mem_out,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_ack,
	output logic busy,
	output rdd_done_t done_out
);
	// ****************************************************************
	// functions
	// ****************************************************************
	function automatic logic [27:0] rec_addr(input logic [27:0] base, input logic [6:0] ch,
		input logic [1:0] idx);
		rec_addr = base + (28'(ch) * REC_BYTES) + {24'h0, idx, 2'h0};
	endfunction : rec_addr

	function automatic logic [27:0] step_addr(input logic [27:0] a, input logic [1:0] code,
		input logic half);
		logic [27:0] inc;
		inc = half ? 28'h2 : 28'h1;
		if (code == UPD_FIXED) step_addr = a;
		else if (code == UPD_DEC) step_addr = a - inc;
		else step_addr = a + inc;
	endfunction : step_addr

	function automatic logic [6:0] hw_chan(input logic [NUM_HW_SRC-1:0] r);
		hw_chan = 7'h00;
		for (int i = NUM_HW_SRC - 1; i >= 0; i--) begin
			if (r[i]) hw_chan = 7'(i + 1);
		end
	endfunction : hw_chan

	// ****************************************************************
	// state
	// ****************************************************************
	rdd_state_t state_r;
	logic [15:0] base_lo_r;
	logic [11:0] base_hi_r;
	logic [6:0] soft_ch_r;
	logic go_r;
	logic en_r;
	logic [AXI_AW-1:0] awaddr_r;
	logic [AXI_AW-1:0] araddr_c;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic [6:0] chan_r;
	logic [6:0] org_r;
	logic hw_r;
	logic [1:0] widx_r;
	logic [31:0] w1_r;
	logic [31:0] w2_r;
	logic [31:0] w3_r;
	logic [27:0] sv_src_r;
	logic [27:0] sv_dst_r;
	logic [7:0] blk_left_r;
	logic [31:0] data_r;
	logic irq_pend_r;
	logic [27:0] base_c;
	logic wr_fire;
	logic mem_done;
	logic unit_end;
	logic is_blk;
	logic chan_end;
	logic cnt_zero;
	logic [23:0] cnt_nxt;
	logic [15:0] tc_nxt;
	logic [7:0] bl_nxt;
	rdd_mem_req_t req_c;

	assign base_c = {base_hi_r, base_lo_r};
	assign araddr_c = s_axi_araddr;
	assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign mem_done = mem_out.req && mem_ack;
	assign unit_end = (state_r == ST_WRITE) && mem_done;
	assign is_blk = (w3_r[31:30] == MODE_BLOCK);
	assign cnt_nxt = w1_r[23:0] - 24'h1;
	assign tc_nxt = w1_r[23:8] - 16'h1;
	assign bl_nxt = blk_left_r - 8'h1;
	assign chan_end = is_blk ? (bl_nxt == 8'h00) :
		((w3_r[31:30] != MODE_SUCC) || (cnt_nxt == 24'h0));
	assign cnt_zero = is_blk ? (tc_nxt == 16'h0) : (cnt_nxt == 24'h0);

	// ****************************************************************
	// axi4-lite slave
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			awaddr_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_r <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_r == ADDR_BASE_LOW || awaddr_r == ADDR_BASE_HIGH ||
					awaddr_r == ADDR_SOFT_TRIG || awaddr_r == ADDR_GLOBAL_EN) ?
					RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			case (araddr_c)
				ADDR_BASE_LOW: s_axi_rdata <= {4'h0, base_c};
				ADDR_BASE_HIGH: s_axi_rdata <= {20'h0, base_hi_r};
				ADDR_SOFT_TRIG: s_axi_rdata <= {24'h0, go_r, soft_ch_r};
				ADDR_GLOBAL_EN: s_axi_rdata <= {31'h0, en_r};
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ****************************************************************
	// software registers
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			base_lo_r <= RST_BASE_LOW;
			base_hi_r <= RST_BASE_HIGH;
			soft_ch_r <= 7'h00;
			go_r <= 1'b0;
			en_r <= 1'b0;
		end else begin
			if (done_out.valid && !done_out.hw) go_r <= 1'b0;
			if (wr_fire && !busy) begin
				if (awaddr_r == ADDR_BASE_LOW) begin
					if (wstrb_r[0]) base_lo_r[7:0] <= wdata_r[7:0];
					if (wstrb_r[1]) base_lo_r[15:8] <= wdata_r[15:8];
					if (wstrb_r[2]) base_hi_r[7:0] <= wdata_r[23:16];
					if (wstrb_r[3]) base_hi_r[11:8] <= wdata_r[27:24];
				end
				if (awaddr_r == ADDR_BASE_HIGH) begin
					if (wstrb_r[0]) base_hi_r[7:0] <= wdata_r[7:0];
					if (wstrb_r[1]) base_hi_r[11:8] <= wdata_r[11:8];
				end
				if (awaddr_r == ADDR_SOFT_TRIG && wstrb_r[0]) begin
					soft_ch_r <= wdata_r[6:0];
					go_r <= wdata_r[7];
				end
			end
			if (wr_fire && awaddr_r == ADDR_GLOBAL_EN && wstrb_r[0]) en_r <= wdata_r[0];
		end
	end

	// ****************************************************************
	// memory request builder
	// ****************************************************************
	always_comb begin
		req_c = '0;
		req_c.req = 1'b1;
		case (state_r)
			ST_FETCH: begin
				req_c.size = SIZE_WORD;
				req_c.addr = rec_addr(base_c, chan_r, widx_r);
			end
			ST_READ: begin
				req_c.size = w2_r[W2_HALF] ? SIZE_HALF : SIZE_BYTE;
				req_c.addr = w2_r[27:0];
			end
			ST_WRITE: begin
				req_c.we = 1'b1;
				req_c.size = w2_r[W2_HALF] ? SIZE_HALF : SIZE_BYTE;
				req_c.addr = w3_r[27:0];
				req_c.wdata = w2_r[W2_HALF] ? {16'h0, data_r[15:0]} : {24'h0, data_r[7:0]};
			end
			ST_STORE: begin
				req_c.we = 1'b1;
				req_c.size = SIZE_WORD;
				req_c.addr = rec_addr(base_c, chan_r, widx_r);
				req_c.wdata = (widx_r == 2'h0) ? w1_r : ((widx_r == 2'h1) ? w2_r : w3_r);
			end
			default: req_c.req = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) mem_out <= '0;
		else if (mem_done) mem_out.req <= 1'b0;
		else if (!mem_out.req) mem_out <= req_c;
	end

	// ****************************************************************
	// sequencer
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_r <= ST_IDLE;
			chan_r <= 7'h00;
			org_r <= 7'h00;
			hw_r <= 1'b0;
			widx_r <= 2'h0;
			irq_pend_r <= 1'b0;
			busy <= 1'b0;
			done_out <= '0;
		end else begin
			done_out.valid <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					if (en_r && (go_r || |hw_req)) begin
						chan_r <= go_r ? soft_ch_r : hw_chan(hw_req);
						org_r <= go_r ? soft_ch_r : hw_chan(hw_req);
						hw_r <= !go_r;
						widx_r <= 2'h0;
						irq_pend_r <= 1'b0;
						busy <= 1'b1;
						state_r <= ST_FETCH;
					end
				end
				ST_FETCH: begin
					if (mem_done) begin
						widx_r <= (widx_r == 2'h2) ? 2'h0 : widx_r + 2'h1;
						if (widx_r == 2'h2) state_r <= ST_READ;
					end
				end
				ST_READ: begin
					if (mem_done) state_r <= ST_WRITE;
				end
				ST_WRITE: begin
					if (mem_done) begin
						state_r <= chan_end ? ST_STORE : ST_READ;
						if (chan_end && cnt_zero && w2_r[W2_IRQ_EN]) irq_pend_r <= 1'b1;
					end
				end
				ST_STORE: begin
					if (mem_done) begin
						widx_r <= (widx_r == 2'h2) ? 2'h0 : widx_r + 2'h1;
						if (widx_r == 2'h2) begin
							if (w1_r[W1_CHAIN]) begin
								chan_r <= w1_r[30:24];
								state_r <= ST_FETCH;
							end else begin
								state_r <= ST_DONE;
								done_out <= '{valid: 1'b1, irq: irq_pend_r, hw: hw_r, chan: org_r};
							end
						end
					end
				end
				ST_DONE: begin
					busy <= 1'b0;
					state_r <= ST_IDLE;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// record working copy
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			w1_r <= '0;
			w2_r <= '0;
			w3_r <= '0;
			sv_src_r <= '0;
			sv_dst_r <= '0;
			blk_left_r <= '0;
			data_r <= '0;
		end else begin
			if (state_r == ST_FETCH && mem_done) begin
				case (widx_r)
					2'h0: begin
						w1_r <= mem_rdata;
						blk_left_r <= mem_rdata[7:0];
					end
					2'h1: begin
						w2_r <= mem_rdata;
						sv_src_r <= mem_rdata[27:0];
					end
					default: begin
						w3_r <= mem_rdata;
						sv_dst_r <= mem_rdata[27:0];
					end
				endcase
			end
			if (state_r == ST_READ && mem_done) data_r <= mem_rdata;
			if (unit_end) begin
				w2_r[27:0] <= step_addr(w2_r[27:0], w2_r[29:28], w2_r[W2_HALF]);
				w3_r[27:0] <= step_addr(w3_r[27:0], w3_r[29:28], w2_r[W2_HALF]);
				if (is_blk) begin
					blk_left_r <= bl_nxt;
					if (bl_nxt == 8'h00) begin
						w1_r[23:8] <= tc_nxt;
						blk_left_r <= w1_r[7:0];
						if (w2_r[29:28] == UPD_INC_RESTORE) w2_r[27:0] <= sv_src_r;
						if (w3_r[29:28] == UPD_INC_RESTORE) w3_r[27:0] <= sv_dst_r;
					end
				end else begin
					w1_r[23:0] <= cnt_nxt;
				end
			end
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_base_hold_busy: assert property (busy |=> $stable(base_c))
		else $error("base changed during transfer");
	a_rec_addr_calc: assert property ($rose(mem_out.req) && state_r == ST_FETCH |->
		mem_out.addr == base_c + 28'(chan_r) * 28'hC + 28'(widx_r) * 28'h4)
		else $error("record address wrong");
	a_enable_gate: assert property (state_r == ST_IDLE && !en_r |=> state_r == ST_IDLE)
		else $error("start accepted while disabled");
	a_go_clears: assert property (done_out.valid && !done_out.hw |=> !go_r)
		else $error("start bit not cleared");
	a_single_one_unit: assert property (unit_end && w3_r[31:30] == MODE_SINGLE
		|=> state_r == ST_STORE)
		else $error("single mode moved more than one unit");
	a_succ_repeat: assert property (unit_end && w3_r[31:30] == MODE_SUCC && !cnt_zero
		|=> state_r == ST_READ)
		else $error("successive mode stopped early");
	a_count_dec: assert property (unit_end && !is_blk
		|=> w1_r[23:0] == $past(w1_r[23:0]) - 24'h1)
		else $error("count not decremented");
	a_src_fixed: assert property (unit_end && w2_r[29:28] == UPD_FIXED
		|=> w2_r[27:0] == $past(w2_r[27:0]))
		else $error("fixed source moved");
	a_dst_restore: assert property (unit_end && is_blk && bl_nxt == 8'h00 &&
		w3_r[29:28] == UPD_INC_RESTORE |=> w3_r[27:0] == sv_dst_r)
		else $error("destination not restored");
	a_chain_next: assert property (state_r == ST_STORE && mem_done && widx_r == 2'h2 &&
		w1_r[W1_CHAIN] |=> state_r == ST_FETCH && chan_r == $past(w1_r[30:24]))
		else $error("chain not followed");
	a_unit_size: assert property ((state_r == ST_READ || state_r == ST_WRITE) && mem_out.req |->
		mem_out.size == {1'b0, w2_r[W2_HALF]})
		else $error("wrong unit size");

	c_single_done: cover property (done_out.valid && w3_r[31:30] == MODE_SINGLE);
	c_chain_taken: cover property (state_r == ST_STORE ##1 state_r == ST_FETCH);
	c_block_end: cover property (unit_end && is_blk && bl_nxt == 8'h00);
	c_irq_done: cover property (done_out.valid && done_out.irq);
endmodule : rdd_engine

// ==== verification/rdd_ram_model.sv ====
`timescale 1ns/1ps
// ****************
// ram partner
// ****************
module rdd_ram_model import rdd_pkg::*; (
	input wire logic clk,
	input wire logic rst_b,
	input rdd_mem_req_t mem_out,
	input wire logic slow,
	output logic [31:0] mem_rdata,
	output logic mem_ack
);
	logic [7:0] mem [logic [27:0]];
	logic [31:0] v;
	int n;
	function automatic logic [7:0] rd(input logic [27:0] a);
		return mem.exists(a) ? mem[a] : 8'h00;
	endfunction : rd
	initial mem_rdata = 32'h5A5A5A5A;
	initial mem_ack = 1'b0;
	// answer after 0 or 3 idle edges; read bus toggles while not answering
	always @(posedge clk) begin
		mem_ack <= 1'b0;
		v = ~mem_rdata;
		if (!rst_b) begin
			n <= 0;
		end else if (mem_out.req && !mem_ack) begin
			if (n >= (slow ? 3 : 0)) begin
				n <= 0;
				mem_ack <= 1'b1;
				if (!mem_out.we) v = 32'h0;
				for (int i = 0; i < (1 << mem_out.size); i++) begin
					if (mem_out.we) mem[mem_out.addr + 28'(i)] = mem_out.wdata[8*i +: 8];
					else v[8*i +: 8] = rd(mem_out.addr + 28'(i));
				end
			end else begin
				n <= n + 1;
			end
		end
		mem_rdata <= v;
	end
endmodule : rdd_ram_model

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
// ****************
// bench top
// ****************
module tb_top import rdd_pkg::*;;
	logic clk, rst_b, slow, hw, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, mem_ack, busy;
	logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, mem_rdata, rv;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [NUM_HW_SRC-1:0] hw_req;
	rdd_mem_req_t mem_out;
	rdd_done_t done_out;
	logic [27:0] base, exp_ra [128];
	logic [31:0] exp_rec [128][3];
	logic exp_irq [128];
	logic [7:0] exp_mem [logic [27:0]];
	int pend [$];
	int seed, ch, err_count, comparisons;

	rdd_engine DUT (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .hw_req, .mem_out, .mem_rdata, .mem_ack, .busy, .done_out);
	rdd_ram_model ram (.clk, .rst_b, .mem_out, .slow, .mem_rdata, .mem_ack);

	always #5 clk = ~clk;
	// peripheral request held until its operation ends
	always @(posedge clk) begin
		if (done_out.valid === 1'b1 && done_out.hw === 1'b1) hw_req[done_out.chan - 7'h1] <= 1'b0;
	end

	// ****************
	// helpers
	// ****************
	function automatic logic [27:0] step(input logic [27:0] a, input logic [1:0] c, input int n);
		return (c == UPD_FIXED) ? a : ((c == UPD_DEC) ? a - 28'(n) : a + 28'(n));
	endfunction : step
	function automatic logic [31:0] rdw(input logic [27:0] a);
		return {ram.rd(a + 28'h3), ram.rd(a + 28'h2), ram.rd(a + 28'h1), ram.rd(a)};
	endfunction : rdw
	task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", what, e, g);
		end
	endtask : check
	task automatic axi_wr(input logic [23:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		logic got;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		got = 1'b0;
		while (!got) begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) begin
				got = 1'b1;
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
			end
		end
	endtask : axi_wr
	task automatic axi_rd(input logic [23:0] a, output logic [31:0] d, output logic [1:0] r);
		logic got;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		got = 1'b0;
		while (!got) begin
			@(posedge clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) begin
				got = 1'b1;
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
			end
		end
	endtask : axi_rd
	task automatic en(input logic v);
		axi_wr(ADDR_GLOBAL_EN, {31'h0, v}, 4'h1, rsp);
	endtask : en
	// record into ram plus expected write-back, copies and flag
	task automatic setup(input int c, input logic [31:0] w [3]);
		logic [27:0] s, d;
		logic [23:0] cnt;
		int u, sz;
		s = w[1][27:0];
		d = w[2][27:0];
		sz = w[1][30] ? 2 : 1;
		u = (w[2][31:30] == MODE_SUCC) ? int'(w[0][23:0]) : 1;
		if (w[2][31:30] == MODE_BLOCK) u = (w[0][7:0] == 8'h0) ? 256 : int'(w[0][7:0]);
		exp_ra[c] = base + 28'(12 * c);
		for (int k = 0; k < 12; k++) ram.mem[exp_ra[c] + 28'(k)] = w[k/4][8*(k%4) +: 8];
		for (int i = -64; i < 64; i++) ram.mem[s + 28'(i)] = 8'($random(seed));
		for (int i = 0; i < u; i++) begin
			for (int b = 0; b < sz; b++) exp_mem[d + 28'(b)] = ram.rd(s + 28'(b));
			s = step(s, w[1][29:28], sz);
			d = step(d, w[2][29:28], sz);
		end
		cnt = w[0][23:0] - 24'(u);
		exp_rec[c][0] = {w[0][31:24], cnt};
		if (w[2][31:30] == MODE_BLOCK) begin
			cnt = {8'h0, w[0][23:8] - 16'h1};
			exp_rec[c][0] = {w[0][31:24], cnt[15:0], w[0][7:0]};
			if (w[1][29:28] == UPD_INC_RESTORE) s = w[1][27:0];
			if (w[2][29:28] == UPD_INC_RESTORE) d = w[2][27:0];
		end
		exp_rec[c][1] = {w[1][31:28], s};
		exp_rec[c][2] = {w[2][31:28], d};
		exp_irq[c] = w[1][31] && cnt == 24'h0;
		pend.push_back(c);
	endtask : setup
	task automatic rand_rec(input int c, input logic [1:0] m, input logic [7:0] lnk);
		logic [31:0] r;
		r = $random(seed);
		setup(c, '{{lnk, (m == MODE_BLOCK) ? 16'(r[1:0]) + 16'h1 : 16'h0, 8'(r[4:2]) + 8'h1},
			{r[8:5], 28'h0200800 + 28'(c << 12)}, {m, r[10:9], 28'h0400800 + 28'(c << 12)}});
	endtask : rand_rec
	task automatic trig(input int c, input logic h);
		if (h) hw_req[c - 1] <= 1'b1;
		else axi_wr(ADDR_SOFT_TRIG, {24'h0, 1'b1, 7'(c)}, 4'h1, rsp);
		en(1'b1);
	endtask : trig
	task automatic wait_done(input int c, input logic h, input logic irq);
		do @(posedge clk); while (done_out.valid !== 1'b1);
		check("done_chan", 32'(c), 32'(done_out.chan));
		check("done_hw", 32'(h), 32'(done_out.hw));
		check("done_irq", 32'(irq), 32'(done_out.irq));
	endtask : wait_done
	task automatic verify();
		foreach (pend[i]) begin
			for (int k = 0; k < 3; k++) begin
				check("record_word", exp_rec[pend[i]][k], rdw(exp_ra[pend[i]] + 28'(4 * k)));
			end
		end
		foreach (exp_mem[a]) check("dest_byte", 32'(exp_mem[a]), 32'(ram.rd(a)));
		exp_mem.delete();
		pend.delete();
	endtask : verify
	task automatic finish_test();
		$display("counts: comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test

	// ****************
	// sequence
	// ****************
	initial begin
		#600000;
		err_count++;
		$display("FAIL watchdog expected end seen hang");
		finish_test();
	end
	initial begin
		seed = 32'h6012;
		{clk, rst_b, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		hw_req = '0;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		axi_rd(ADDR_BASE_LOW, rv, rsp);
		check("base_reset", 32'h00C003A0, rv);
		check("base_rd_resp", 32'(RESP_OKAY), 32'(rsp));
		axi_rd(ADDR_BASE_HIGH, rv, rsp);
		check("base_high_reset", 32'h000000C0, rv);
		axi_rd(24'h000010, rv, rsp);
		check("unmapped_resp", 32'(RESP_SLVERR), 32'(rsp));
		check("unmapped_data", 32'h0, rv);
		axi_wr(24'h000010, 32'h0, 4'hF, rsp);
		check("unmapped_wr_resp", 32'(RESP_SLVERR), 32'(rsp));
		$display("test reset_values done");
		base = 28'h0123450;
		axi_wr(ADDR_BASE_LOW, {16'h0, base[15:0]}, 4'h3, rsp);
		axi_wr(ADDR_BASE_HIGH, {20'h0, base[27:16]}, 4'h3, rsp);
		check("base_high_wr_resp", 32'(RESP_OKAY), 32'(rsp));
		axi_rd(ADDR_BASE_LOW, rv, rsp);
		check("base_half", {4'h0, base}, rv);
		base = {12'h001, 16'($random(seed)) & 16'hFFFC};
		axi_wr(ADDR_BASE_LOW, {4'h0, base}, 4'hF, rsp);
		axi_rd(ADDR_BASE_HIGH, rv, rsp);
		check("base_word_high", {20'h0, base[27:16]}, rv);
		$display("test base_address done");
		rand_rec(5, MODE_SUCC, 8'h00);
		rand_rec(2, MODE_BLOCK, 8'h00);
		axi_wr(ADDR_SOFT_TRIG, 32'h00000085, 4'h1, rsp);
		hw_req[1] <= 1'b1;
		repeat (20) @(posedge clk);
		check("busy_disabled", 32'h0, 32'(busy));
		en(1'b1);
		wait_done(5, 1'b0, exp_irq[5]);
		wait_done(2, 1'b1, exp_irq[2]);
		axi_rd(ADDR_SOFT_TRIG, rv, rsp);
		check("go_cleared", 32'h00000005, rv);
		verify();
		$display("test enable_priority done");
		for (int it = 0; it < 9; it++) begin
			en(1'b0);
			ch = 1 + (($random(seed) & 32'h7FFFFFFF) % 27);
			hw = 1'($random(seed));
			slow <= 1'($random(seed));
			rand_rec(ch, 2'(it % 3), 8'h00);
			trig(ch, hw);
			wait_done(ch, hw, exp_irq[ch]);
			verify();
		end
		$display("test random_modes done");
		en(1'b0);
		setup(40, '{32'hA9000000, 32'h80228800, 32'h20428800});
		setup(41, '{32'h00000104, 32'hE0229800, 32'hA0429800});
		trig(40, 1'b0);
		wait_done(40, 1'b0, exp_irq[40] | exp_irq[41]);
		verify();
		$display("test chain_wrap done");
		en(1'b0);
		slow <= 1'b1;
		setup(50, '{32'h00000008, 32'h70232800, 32'h70432800});
		trig(50, 1'b0);
		repeat (4) @(posedge clk);
		check("busy_active", 32'h1, 32'(busy));
		axi_wr(ADDR_BASE_LOW, 32'h00002000, 4'hF, rsp);
		check("busy_wr_resp", 32'(RESP_OKAY), 32'(rsp));
		wait_done(50, 1'b0, exp_irq[50]);
		axi_rd(ADDR_BASE_LOW, rv, rsp);
		check("base_kept", {4'h0, base}, rv);
		verify();
		$display("test busy_base_write done");
		finish_test();
	end
endmodule : tb_top
